/* File: hw/refclk_cfg.svh */
// Functional notes
// RULE_01: enable bit set runs the reference generator; clear disables it.
// RULE_02: stop-in-idle set halts the generator in idle; clear keeps it running.
// RULE_03: pin carries the reference clock only while pin drive enable is set.
// RULE_04: run-in-sleep set keeps generator running in sleep; clear stops it.
// RULE_05: software sets switch request; hardware holds it, clears when divider applied.
// RULE_06: active status is one while clock runs, zero once stopped.
// RULE_07: four-bit source select picks one of eight sources; codes 8 to 15 reserved.
// RULE_08: fifteen-bit integer divider divides selected source by twice its value.
// RULE_09: integer divider of zero passes the selected source through undivided.
// RULE_10: nine-bit trim adds n/512 to the divider for each half period.
// RULE_11: unimplemented register bits ignore writes and read as zero.
// RULE_12: fraction accumulator lengthens a half period by one cycle on overflow.
`ifndef REFCLK_CFG_SVH
`define REFCLK_CFG_SVH
`define ADDR_W 4
`define DATA_W 16
`define OFF_CONTROL_LOW 4'h0
`define OFF_DIVIDER_HIGH 4'h4
`define OFF_FRACTION_TRIM 4'h8
`define BIT_ENABLE 15
`define BIT_STOP_IDLE 13
`define BIT_PIN_DRIVE 12
`define BIT_RUN_SLEEP 11
`define BIT_SWITCH_REQ 9
`define BIT_ACTIVE 8
`define SEL_MSB 3
`define DIV_MSB 14
`define TRIM_MSB 15
`define TRIM_LSB 7
`define TRIM_W 9
`define NUM_SRC 8
`define SEL_RESERVED_MIN 4'h8
`define CTL_RESET 16'h0000
`define DIV_RESET 15'h0000
`define TRIM_RESET 9'h000
`endif

/* File: hw/refclk_pkg.sv */
package refclk_pkg;
  typedef enum logic [1:0] {
    GEN_STOPPED,
    GEN_HIGH,
    GEN_LOW
  } gen_state_e;
endpackage

/* File: hw/reference_clock_divider.sv */
// Our own choices: the register addresses and the strobed register port.
`include "refclk_cfg.svh"

module reference_clock_divider
  import refclk_pkg::*;
#(
  parameter int DIV_W = 15
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic [`DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [`DATA_W-1:0] reg_rdata_o,
  // 0 system, 1 peripheral_clock, 2 primary osc, 3 fast_rc_oscillator,
  // 4 low_power_rc_oscillator, 5 backup_rc_oscillator, 6 vco/4, 7 reference_clock_in_pin
  input wire logic [`NUM_SRC-1:0] source_clk_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  output logic reference_clock_out_pin_o,
  output logic refgen_active_o
);

  // reset release: asynchronous assert, synchronous release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // source sampling: each source must be at most a quarter of core_clk_i
  // to be seen cleanly, since every edge passes the three-flop filter
  logic [`NUM_SRC-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= source_clk_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // register file
  logic enable_q, enable_d;
  logic stop_idle_q, stop_idle_d;
  logic pin_drive_q, pin_drive_d;
  logic run_sleep_q, run_sleep_d;
  logic switch_req_q, switch_req_d;
  logic [`SEL_MSB:0] sel_q, sel_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [`TRIM_W-1:0] trim_q, trim_d;
  logic [`DATA_W-1:0] rdata_q, rdata_d;
  logic switch_done;
  logic active_q;
  localparam logic [`DATA_W-1:0] CTL_RST = `CTL_RESET;
  localparam int SRC_IDX_W = $clog2(`NUM_SRC);

  always_comb begin
    enable_d = enable_q;
    stop_idle_d = stop_idle_q;
    pin_drive_d = pin_drive_q;
    run_sleep_d = run_sleep_q;
    sel_d = sel_q;
    div_d = div_q;
    trim_d = trim_q;
    switch_req_d = switch_req_q;
    rdata_d = '0;
    if (switch_done) begin
      switch_req_d = 1'b0; // [RULE_05]
    end
    if (reg_write_i) begin
      if (reg_addr_i == `OFF_CONTROL_LOW) begin
        enable_d = reg_wdata_i[`BIT_ENABLE];
        stop_idle_d = reg_wdata_i[`BIT_STOP_IDLE];
        pin_drive_d = reg_wdata_i[`BIT_PIN_DRIVE];
        run_sleep_d = reg_wdata_i[`BIT_RUN_SLEEP];
        sel_d = reg_wdata_i[`SEL_MSB:0];
        // a software set beats a completion in the same cycle
        if (reg_wdata_i[`BIT_SWITCH_REQ]) begin
          switch_req_d = 1'b1; // [RULE_05]
        end
      end else if (reg_addr_i == `OFF_DIVIDER_HIGH) begin
        div_d = reg_wdata_i[DIV_W-1:0]; // [RULE_11]
      end else if (reg_addr_i == `OFF_FRACTION_TRIM) begin
        trim_d = reg_wdata_i[`TRIM_MSB:`TRIM_LSB]; // [RULE_11]
      end
    end
    if (reg_read_i) begin
      if (reg_addr_i == `OFF_CONTROL_LOW) begin
        rdata_d[`BIT_ENABLE] = enable_q;
        rdata_d[`BIT_STOP_IDLE] = stop_idle_q;
        rdata_d[`BIT_PIN_DRIVE] = pin_drive_q;
        rdata_d[`BIT_RUN_SLEEP] = run_sleep_q;
        rdata_d[`BIT_SWITCH_REQ] = switch_req_q;
        rdata_d[`BIT_ACTIVE] = active_q; // [RULE_06]
        rdata_d[`SEL_MSB:0] = sel_q;
      end else if (reg_addr_i == `OFF_DIVIDER_HIGH) begin
        rdata_d[DIV_W-1:0] = div_q;
      end else if (reg_addr_i == `OFF_FRACTION_TRIM) begin
        rdata_d[`TRIM_MSB:`TRIM_LSB] = trim_q;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q <= CTL_RST[`BIT_ENABLE];
      stop_idle_q <= CTL_RST[`BIT_STOP_IDLE];
      pin_drive_q <= CTL_RST[`BIT_PIN_DRIVE];
      run_sleep_q <= CTL_RST[`BIT_RUN_SLEEP];
      switch_req_q <= CTL_RST[`BIT_SWITCH_REQ];
      sel_q <= CTL_RST[`SEL_MSB:0];
      div_q <= `DIV_RESET;
      trim_q <= `TRIM_RESET;
      rdata_q <= '0;
    end else begin
      enable_q <= enable_d;
      stop_idle_q <= stop_idle_d;
      pin_drive_q <= pin_drive_d;
      run_sleep_q <= run_sleep_d;
      switch_req_q <= switch_req_d;
      sel_q <= sel_d;
      div_q <= div_d;
      trim_q <= trim_d;
      rdata_q <= rdata_d;
    end
  end

  // generator
  logic run_ok;
  logic sel_valid;
  logic src_lvl;
  logic src_rise;
  gen_state_e state_q, state_d;
  logic [DIV_W-1:0] act_div_q, act_div_d;
  logic [DIV_W:0] cnt_q, cnt_d;
  logic [`TRIM_W-1:0] acc_q, acc_d;
  logic ext_q, ext_d;
  logic out_q, out_d;
  logic active_d;
  logic pin_q, pin_d;
  logic [DIV_W:0] half_len;
  logic [`TRIM_W:0] acc_sum;

  always_comb begin
    run_ok = enable_q; // [RULE_01]
    if (idle_mode_i && stop_idle_q) begin
      run_ok = 1'b0; // [RULE_02]
    end
    if (sleep_mode_i && !run_sleep_q) begin
      run_ok = 1'b0; // [RULE_04]
    end
    sel_valid = (sel_q < `SEL_RESERVED_MIN); // [RULE_07]
    src_lvl = sel_valid ? lvl_q[sel_q[SRC_IDX_W-1:0]] : 1'b0; // [RULE_07]
    src_rise = sel_valid && lvl_d[sel_q[SRC_IDX_W-1:0]] && !lvl_q[sel_q[SRC_IDX_W-1:0]];
    half_len = {1'b0, act_div_q} + {{DIV_W{1'b0}}, ext_q}; // [RULE_12]
    acc_sum = {1'b0, acc_q} + {1'b0, trim_q}; // [RULE_10]
  end

  always_comb begin
    state_d = state_q;
    act_div_d = act_div_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    ext_d = ext_q;
    out_d = out_q;
    switch_done = 1'b0;
    case (state_q)
      GEN_STOPPED: begin
        out_d = 1'b0;
        cnt_d = '0;
        acc_d = '0;
        ext_d = 1'b0;
        // while stopped a pending divider change takes effect at once
        if (switch_req_q) begin
          act_div_d = div_q;
          switch_done = 1'b1; // [RULE_05]
        end
        if (run_ok) begin
          state_d = GEN_LOW;
        end
      end
      GEN_HIGH, GEN_LOW: begin
        if (act_div_q == '0) begin
          out_d = src_lvl; // [RULE_09]
          if (switch_req_q) begin
            act_div_d = div_q;
            switch_done = 1'b1; // [RULE_05]
          end
          if (!run_ok && !src_lvl) begin
            state_d = GEN_STOPPED;
          end
        end else if (src_rise) begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_d >= half_len) begin
            // half period is act_div plus possible overflow cycle
            cnt_d = '0; // [RULE_08]
            acc_d = acc_sum[`TRIM_W-1:0]; // [RULE_12]
            ext_d = acc_sum[`TRIM_W]; // [RULE_12]
            out_d = !out_q; // [RULE_08]
            state_d = out_q ? GEN_LOW : GEN_HIGH;
            // switch on a falling edge so no runt high phase appears
            if (out_q && switch_req_q) begin
              act_div_d = div_q;
              switch_done = 1'b1; // [RULE_05]
            end
            if (out_q && !run_ok) begin
              state_d = GEN_STOPPED; // [RULE_01]
            end
          end
        end
        // a stop while low must also drop a rise due now, or a runt pulse escapes
        if (!run_ok && !out_q && act_div_q != '0) begin
          state_d = GEN_STOPPED;
          out_d = 1'b0;
        end
      end
      default: begin
        state_d = GEN_STOPPED;
      end
    endcase
    active_d = (state_d != GEN_STOPPED); // [RULE_06]
    pin_d = out_d && pin_drive_q; // [RULE_03]
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= GEN_STOPPED;
      act_div_q <= `DIV_RESET;
      cnt_q <= '0;
      acc_q <= '0;
      ext_q <= 1'b0;
      out_q <= 1'b0;
      active_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      act_div_q <= act_div_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      ext_q <= ext_d;
      out_q <= out_d;
      active_q <= active_d;
      pin_q <= pin_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reference_clock_out_pin_o = pin_q;
  assign refgen_active_o = active_q;

  // checks
  sequence write_ctl_s;
    reg_write_i && reg_addr_i == `OFF_CONTROL_LOW;
  endsequence

  AST_DISABLED_STAYS_STOPPED: assert property ( // [RULE_01]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (!enable_q && state_q == GEN_STOPPED) |=> state_q == GEN_STOPPED
  ) else $error("generator started while disabled");

  AST_IDLE_STOP: assert property ( // [RULE_02]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (idle_mode_i && stop_idle_q && state_q == GEN_STOPPED) |=> !active_q
  ) else $error("generator ran in idle with stop set");

  AST_PIN_GATED: assert property ( // [RULE_03]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    !pin_drive_q |=> !reference_clock_out_pin_o
  ) else $error("pin driven while drive disabled");

  AST_SLEEP_STOP: assert property ( // [RULE_04]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (sleep_mode_i && !run_sleep_q && state_q == GEN_STOPPED) |=> !active_q
  ) else $error("generator ran in sleep without run bit");

  AST_SWITCH_SET_WINS: assert property ( // [RULE_05]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (write_ctl_s and reg_wdata_i[`BIT_SWITCH_REQ]) |=> switch_req_q
  ) else $error("switch request lost");

  AST_SWITCH_APPLIES: assert property ( // [RULE_05]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (switch_req_q && state_q == GEN_STOPPED && !(reg_write_i && reg_addr_i == `OFF_CONTROL_LOW))
      |=> act_div_q == $past(div_q)
  ) else $error("divider not applied while stopped");

  AST_ACTIVE_TRACKS: assert property ( // [RULE_06]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    !active_q |-> !out_q
  ) else $error("clock output high while status reads stopped");

  AST_RESERVED_SILENT: assert property ( // [RULE_07]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (sel_q >= `SEL_RESERVED_MIN && act_div_q == '0 && state_q != GEN_STOPPED)
      |=> !out_q
  ) else $error("reserved source produced a clock");

  AST_HALF_LEN: assert property ( // [RULE_08]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (state_q != GEN_STOPPED && act_div_q != '0) |-> cnt_q < {1'b0, act_div_q} + 1'b1
  ) else $error("half period count overran");

  AST_READ_ZERO: assert property ( // [RULE_11]
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (reg_read_i && reg_addr_i == `OFF_FRACTION_TRIM) |=> reg_rdata_o[`TRIM_LSB-1:0] == '0
  ) else $error("unimplemented trim bits read nonzero");

endmodule

/* File: verif/reference_clock_divider_tb.sv */
`include "refclk_cfg.svh"

module reference_clock_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [`ADDR_W-1:0] reg_addr_i = '0;
  logic [`DATA_W-1:0] reg_wdata_i = '0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [`DATA_W-1:0] reg_rdata_o;
  logic [`NUM_SRC-1:0] source_clk_i = '0;
  logic idle_mode_i = 1'b0;
  logic sleep_mode_i = 1'b0;
  logic reference_clock_out_pin_o;
  logic refgen_active_o;
  int src_cnt [8] = '{default: 0};
  int mismatches = 0;
  int comparisons = 0;

  reference_clock_divider dut (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o),
    .source_clk_i(source_clk_i),
    .idle_mode_i(idle_mode_i),
    .sleep_mode_i(sleep_mode_i),
    .reference_clock_out_pin_o(reference_clock_out_pin_o),
    .refgen_active_o(refgen_active_o)
  );

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // source n has a period of 2*(4+n) core cycles, so a wrong select shows as a wrong period
  always @(posedge core_clk_i) begin
    for (int n = 0; n < 8; n++) begin
      if (src_cnt[n] == 3 + n) begin
        src_cnt[n] <= 0;
        source_clk_i[n] <= ~source_clk_i[n];
      end else begin
        src_cnt[n] <= src_cnt[n] + 1;
      end
    end
  end

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("[FAIL] t=%0t wait ran out", $time);
    close_out();
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    @(negedge core_clk_i);
    v = reg_rdata_o;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    reg_rd(a, v);
    check(v, exp);
  endtask

  task automatic wait_active(input logic exp, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(negedge core_clk_i);
      if (refgen_active_o === exp) break;
    end
    if (i == bound) give_up();
    check({15'h0, refgen_active_o}, {15'h0, exp});
  endtask

  task automatic hold_act(input logic exp, input int n);
    repeat (n) begin
      @(negedge core_clk_i);
      check({15'h0, refgen_active_o}, {15'h0, exp});
    end
  endtask

  task automatic hold_pin_low(input int n);
    repeat (n) begin
      @(negedge core_clk_i);
      check({15'h0, reference_clock_out_pin_o}, 16'h0000);
    end
  endtask

  task automatic edge_rise(input int bound);
    int i;
    logic prev;
    @(negedge core_clk_i);
    prev = reference_clock_out_pin_o;
    for (i = 0; i < bound; i++) begin
      @(negedge core_clk_i);
      if (prev === 1'b0 && reference_clock_out_pin_o === 1'b1) break;
      prev = reference_clock_out_pin_o;
    end
    if (i == bound) give_up();
  endtask

  // the first period after a start or a switch is skipped, the second is compared
  task automatic meas(input int exp);
    int p;
    logic prev;
    edge_rise(600);
    repeat (2) begin
      prev = 1'b1;
      for (p = 1; p < 600; p++) begin
        @(negedge core_clk_i);
        if (prev === 1'b0 && reference_clock_out_pin_o === 1'b1) break;
        prev = reference_clock_out_pin_o;
      end
      if (p == 600) give_up();
    end
    check(p[15:0], exp[15:0]);
  endtask

  initial begin
    int i;
    logic [15:0] v;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rd_chk(4'h0, 16'h0000);
    rd_chk(4'h4, 16'h0000);
    rd_chk(4'h8, 16'h0000);
    reg_wr(4'h0, 16'h780F);
    rd_chk(4'h0, 16'h380F);
    reg_wr(4'h4, 16'hFFFF);
    rd_chk(4'h4, 16'h7FFF);
    reg_wr(4'h8, 16'hFFFF);
    rd_chk(4'h8, 16'hFF80);
    reg_wr(4'hC, 16'hFFFF);
    rd_chk(4'hC, 16'h0000);
    reg_wr(4'h4, 16'h0000);
    reg_wr(4'h8, 16'h0000);
    reg_wr(4'h0, 16'h0200);
    for (int s = 0; s < 9; s++) begin
      reg_wr(4'h0, 16'h9000 | s[15:0]);
      if (s < 8) meas(2 * (4 + s));
      else hold_pin_low(64);
      reg_wr(4'h0, 16'h0000);
      wait_active(1'b0, 200);
    end
    reg_wr(4'h4, 16'h0002);
    reg_wr(4'h0, 16'h0200);
    rd_chk(4'h0, 16'h0000);
    reg_wr(4'h0, 16'h9000);
    wait_active(1'b1, 50);
    meas(32);
    foreach (v[k]) begin
      if (k > 1) continue;
      reg_wr(4'h0, 16'h0000);
      wait_active(1'b0, 300);
      reg_wr(4'h8, k == 0 ? 16'h8000 : 16'hFF80);
      reg_wr(4'h4, 16'h0001);
      reg_wr(4'h0, 16'h0200);
      reg_wr(4'h0, 16'h9000);
      meas(k == 0 ? 24 : 32);
    end
    reg_wr(4'h0, 16'h0000);
    wait_active(1'b0, 300);
    reg_wr(4'h8, 16'h0000);
    reg_wr(4'h4, 16'h0010);
    reg_wr(4'h0, 16'h0200);
    reg_wr(4'h0, 16'h9000);
    meas(256);
    reg_wr(4'h4, 16'h0002);
    reg_wr(4'h0, 16'h9200);
    rd_chk(4'h0, 16'h9300);
    for (i = 0; i < 100; i++) begin
      reg_rd(4'h0, v);
      if (v[9] === 1'b0) break;
    end
    if (i == 100) give_up();
    meas(32);
    reg_wr(4'h0, 16'h8000);
    repeat (3) @(posedge core_clk_i);
    hold_pin_low(64);
    hold_act(1'b1, 8);
    reg_wr(4'h0, 16'hA000);
    idle_mode_i <= 1'b1;
    wait_active(1'b0, 100);
    @(posedge core_clk_i);
    idle_mode_i <= 1'b0;
    wait_active(1'b1, 20);
    reg_wr(4'h0, 16'h8000);
    idle_mode_i <= 1'b1;
    hold_act(1'b1, 100);
    @(posedge core_clk_i);
    idle_mode_i <= 1'b0;
    sleep_mode_i <= 1'b1;
    wait_active(1'b0, 100);
    @(posedge core_clk_i);
    sleep_mode_i <= 1'b0;
    wait_active(1'b1, 20);
    reg_wr(4'h0, 16'h8800);
    sleep_mode_i <= 1'b1;
    hold_act(1'b1, 100);
    @(posedge core_clk_i);
    sleep_mode_i <= 1'b0;
    reg_wr(4'h0, 16'h0000);
    wait_active(1'b0, 100);
    rd_chk(4'h0, 16'h0000);
    close_out();
  end
endmodule
